// ==== hw/ch2_pwm_defs.vh ====
`ifndef CH2_PWM_DEFS_VH
`define CH2_PWM_DEFS_VH
// ----------------------------------------
// register offsets (register index)
// ----------------------------------------
`define OFF_PWM_CTRL      8'h16
`define OFF_ILIM_CFG      8'h17
`define OFF_FAULT_STAT    8'h15
`define RST_PWM_CTRL      16'h0000
`define RST_ILIM_CFG      16'h0088
// ----------------------------------------
// field positions
// ----------------------------------------
`define PWM_EN_BIT        0
`define DUTY_LSB          1
`define DUTY_MSB          8
`define FREQ_LSB          9
`define FREQ_MSB          11
`define THR_LSB           4
`define THR_MSB           7
`define DUR_LSB           8
`define DUR_MSB           10
`define WIRE_EN_BIT       11
`define MODE_LSB          12
`define MODE_MSB          13
`define PEAK_LSB          14
`define PEAK_MSB          15
`define STAT_OTW_BIT      0
`define STAT_OLON_BIT     1
`define STAT_PWMERR_BIT   12
// ----------------------------------------
// charge modes
// ----------------------------------------
`define MODE_NONE         2'h0
`define MODE_DVDT         2'h1
`define MODE_ILIM         2'h2
`define MODE_PULSE        2'h3
// ----------------------------------------
// timing (clock 50 MHz)
// ----------------------------------------
`define CLK_HZ            50000000
`define MIN_ON_US         200
`define MIN_ON_CYC        26'h0002710 // 200 us in 50 MHz cycles
`define MS_LAST_CYC       16'hC34F    // last cycle of one millisecond
`endif

// ==== hw/pwm_period_gen.v ====
`include "ch2_pwm_defs.vh"
module pwm_period_gen (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // settings
  input  wire        run,
  input  wire [2:0]  freq_sel,
  input  wire [7:0]  duty,
  // output
  output reg         pulse_ff
);
  // ----------------------------------------
  // period lookup, cycles at 50 MHz
  // ----------------------------------------
  function [25:0] period_cycles;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: period_cycles = 26'd62500000; // 0.8 Hz
        3'h1: period_cycles = 26'd14705882; // 3.4 Hz
        3'h2: period_cycles = 26'd3623188;  // 13.8 Hz
        3'h3: period_cycles = 26'd450450;   // 111 Hz
        3'h4: period_cycles = 26'd226244;   // 221 Hz
        3'h5: period_cycles = 26'd112866;   // 443 Hz
        3'h6: period_cycles = 26'd56497;    // 885 Hz
        default: period_cycles = 26'd28248; // 1770 Hz
      endcase
    end
  endfunction

  reg  [25:0] cnt_ff;
  reg  [11:0] cfg_ff;
  wire [25:0] period = period_cycles(freq_sel);
  wire [33:0] on_prod = period * duty;
  wire [25:0] on_cyc = on_prod[33:8];  // duty/256 of the period
  wire [11:0] cfg_now = {run, freq_sel, duty};

  // free counter, restarted when the setup changes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff   <= 26'h0000000;
      cfg_ff   <= 12'h000;
      pulse_ff <= 1'b0;
    end else begin
      cfg_ff <= cfg_now;
      if (!run || cfg_now != cfg_ff || cnt_ff >= period - 26'd1) begin
        cnt_ff <= 26'h0000000;
      end else begin
        cnt_ff <= cnt_ff + 26'd1;
      end
      pulse_ff <= run && (cnt_ff < on_cyc);
    end
  end
endmodule // pwm_period_gen

// ==== hw/ch2_pwm_inrush.v ====
`include "ch2_pwm_defs.vh"
module ch2_pwm_inrush (
  // clock and reset
  input  wire        CLK,
  input  wire        RESETN,
  // register port
  input  wire [7:0]  REG_ADDR,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [15:0] REG_WDATA,
  output reg  [15:0] REG_RDATA,
  // channel state from the analog side
  input  wire        SWITCH_ON_COMMAND,
  input  wire        OVERTEMP_RAW,
  input  wire        OPEN_LOAD_RAW,
  input  wire        OPEN_LOAD_DETECT_ENABLE,
  input  wire [3:0]  STEADY_OVERCURRENT_THRESHOLD,
  // channel controls
  output reg         GATE_ON,
  output reg         INRUSH_ACTIVE,
  output reg  [1:0]  CHARGE_MODE,
  output reg  [3:0]  OVERCURRENT_CODE,
  output reg         CURRENT_DIVIDE_BY_5,
  output reg  [3:0]  RAMP_RATE_CODE,
  output reg  [3:0]  PULSE_PARAM_CODE,
  output reg  [1:0]  PULSE_PEAK_CURRENT_SELECT,
  output reg         WIRE_HEAT_ACCUMULATE
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [3:0] sync1_ff;
  reg [3:0] sync2_ff;
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {SWITCH_ON_COMMAND, OVERTEMP_RAW, OPEN_LOAD_RAW, OPEN_LOAD_DETECT_ENABLE};
      sync2_ff <= sync1_ff;
    end
  end
  wire sw_on   = sync2_ff[3];
  wire otw     = sync2_ff[2];
  wire ol_raw  = sync2_ff[1];
  wire ol_en   = sync2_ff[0];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [15:0] pwm_ctrl_ff;
  reg  [15:0] ilim_cfg_ff;
  reg         pwm_err_ff;
  wire [2:0]  freq_sel = pwm_ctrl_ff[`FREQ_MSB:`FREQ_LSB];
  wire [7:0]  duty     = pwm_ctrl_ff[`DUTY_MSB:`DUTY_LSB];
  wire        pwm_en   = pwm_ctrl_ff[`PWM_EN_BIT];
  wire [1:0]  mode     = ilim_cfg_ff[`MODE_MSB:`MODE_LSB];
  wire [2:0]  dur_sel  = ilim_cfg_ff[`DUR_MSB:`DUR_LSB];
  wire [3:0]  thr      = ilim_cfg_ff[`THR_MSB:`THR_LSB];

  // on-time check for a requested enable; reuses the period table in cycles
  function [25:0] period_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: period_of = 26'd62500000;
        3'h1: period_of = 26'd14705882;
        3'h2: period_of = 26'd3623188;
        3'h3: period_of = 26'd450450;
        3'h4: period_of = 26'd226244;
        3'h5: period_of = 26'd112866;
        3'h6: period_of = 26'd56497;
        default: period_of = 26'd28248;
      endcase
    end
  endfunction

  wire [2:0]  w_freq   = REG_WDATA[`FREQ_MSB:`FREQ_LSB];
  wire [7:0]  w_duty   = REG_WDATA[`DUTY_MSB:`DUTY_LSB];
  wire [33:0] w_onprod = period_of(w_freq) * w_duty;
  wire        w_on_ok  = w_onprod[33:8] > `MIN_ON_CYC;
  wire        w_en_ok  = w_on_ok && (mode == `MODE_NONE);
  wire        wr_pwm   = REG_WR && (REG_ADDR == `OFF_PWM_CTRL);
  wire        wr_ilim  = REG_WR && (REG_ADDR == `OFF_ILIM_CFG);
  wire        rd_stat  = REG_RD && (REG_ADDR == `OFF_FAULT_STAT);

  // writes; a refused enable stores zero in the enable bit and raises the error
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pwm_ctrl_ff <= `RST_PWM_CTRL;
      ilim_cfg_ff <= `RST_ILIM_CFG;
      pwm_err_ff  <= 1'b0;
    end else begin
      if (wr_pwm) begin
        pwm_ctrl_ff <= {4'h0, REG_WDATA[11:1], REG_WDATA[0] & w_en_ok};
      end
      if (wr_ilim) begin
        ilim_cfg_ff <= REG_WDATA;
      end
      // set beats the read clear
      if (wr_pwm && REG_WDATA[0] && !w_en_ok) begin
        pwm_err_ff <= 1'b1;
      end else if (rd_stat) begin
        pwm_err_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // inrush window timer
  // ----------------------------------------
  function [6:0] window_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: window_ms = 7'd0;
        3'h1: window_ms = 7'd2;
        3'h2: window_ms = 7'd4;
        3'h3: window_ms = 7'd6;
        3'h4: window_ms = 7'd10;
        3'h5: window_ms = 7'd20;
        3'h6: window_ms = 7'd50;
        default: window_ms = 7'd100;
      endcase
    end
  endfunction

  reg        sw_prev_ff;
  reg [15:0] ms_cnt_ff;
  reg [6:0]  ms_left_ff;
  reg        win_ff;
  wire       win_start = sw_on && !sw_prev_ff;
  // window opens on each switch-on edge whose length is nonzero and runs its length in ms
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sw_prev_ff <= 1'b0;
      ms_cnt_ff  <= 16'h0000;
      ms_left_ff <= 7'h00;
      win_ff     <= 1'b0;
    end else begin
      sw_prev_ff <= sw_on;
      if (!sw_on) begin
        win_ff <= 1'b0;
      end else if (win_start) begin
        ms_left_ff <= window_ms(dur_sel);
        ms_cnt_ff  <= 16'h0000;
        win_ff     <= (window_ms(dur_sel) != 7'd0);
      end else if (win_ff) begin
        if (ms_cnt_ff == `MS_LAST_CYC) begin
          ms_cnt_ff  <= 16'h0000;
          ms_left_ff <= ms_left_ff - 7'd1;
          if (ms_left_ff == 7'd1) begin
            win_ff <= 1'b0;
          end
        end else begin
          ms_cnt_ff <= ms_cnt_ff + 16'd1;
        end
      end
    end
  end

  // charging with a nonzero mode inside the window; the opening cycle counts
  // too, so neither a pulse nor heating slips in before win_ff rises
  wire win_next = win_start && (window_ms(dur_sel) != 7'd0);
  wire charging = (win_ff || win_next) && (mode != `MODE_NONE);

  // ----------------------------------------
  // pulse generator
  // ----------------------------------------
  wire pulse;
  pwm_period_gen u_gen (
    .clk      (CLK),
    .resetn   (RESETN),
    .run      (pwm_en && sw_on && !charging),
    .freq_sel (freq_sel),
    .duty     (duty),
    .pulse_ff (pulse)
  );

  // ----------------------------------------
  // channel outputs
  // ----------------------------------------
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      GATE_ON                   <= 1'b0;
      INRUSH_ACTIVE             <= 1'b0;
      CHARGE_MODE               <= 2'h0;
      OVERCURRENT_CODE          <= 4'h8;
      CURRENT_DIVIDE_BY_5       <= 1'b0;
      RAMP_RATE_CODE            <= 4'h0;
      PULSE_PARAM_CODE          <= 4'h0;
      PULSE_PEAK_CURRENT_SELECT <= 2'h0;
      WIRE_HEAT_ACCUMULATE      <= 1'b0;
    end else begin
      // plain follow unless pulsing is allowed
      GATE_ON <= (pwm_en && !charging) ? pulse : sw_on;
      INRUSH_ACTIVE <= win_ff;
      CHARGE_MODE   <= mode;
      // threshold: inrush field in mode zero or limit mode, steady after
      if (win_ff && (mode == `MODE_NONE || mode == `MODE_ILIM)) begin
        OVERCURRENT_CODE <= thr;
      end else begin
        OVERCURRENT_CODE <= STEADY_OVERCURRENT_THRESHOLD;
      end
      CURRENT_DIVIDE_BY_5 <= win_ff && (mode == `MODE_ILIM);
      RAMP_RATE_CODE   <= (mode == `MODE_DVDT) ? thr : 4'h0;
      PULSE_PARAM_CODE <= (mode == `MODE_PULSE) ? thr : 4'h0;
      PULSE_PEAK_CURRENT_SELECT <= (mode == `MODE_PULSE) ?
                                   ilim_cfg_ff[`PEAK_MSB:`PEAK_LSB] : 2'h0;
      WIRE_HEAT_ACCUMULATE <= ilim_cfg_ff[`WIRE_EN_BIT] && sw_on && !charging;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      if (REG_ADDR == `OFF_PWM_CTRL) begin
        REG_RDATA <= pwm_ctrl_ff;
      end else if (REG_ADDR == `OFF_ILIM_CFG) begin
        REG_RDATA <= ilim_cfg_ff;
      end else if (REG_ADDR == `OFF_FAULT_STAT) begin
        REG_RDATA <= {3'h0, pwm_err_ff, 10'h000, ol_raw & ol_en, otw};
      end else begin
        REG_RDATA <= 16'h0000;
      end
    end
  end
endmodule // ch2_pwm_inrush

// ==== testbench/ch2_pwm_inrush_checker.sv ====
module ch2_pwm_inrush_checker (
  // clock and reset
  input logic        CLK,
  input logic        RESETN,
  // register port
  input logic [7:0]  REG_ADDR,
  input logic        REG_RD,
  input logic [15:0] REG_RDATA,
  // channel inputs
  input logic        SWITCH_ON_COMMAND,
  input logic        OVERTEMP_RAW,
  input logic        OPEN_LOAD_DETECT_ENABLE,
  input logic [3:0]  STEADY_OVERCURRENT_THRESHOLD,
  // channel outputs
  input logic        GATE_ON,
  input logic        INRUSH_ACTIVE,
  input logic [1:0]  CHARGE_MODE,
  input logic [3:0]  OVERCURRENT_CODE,
  input logic        CURRENT_DIVIDE_BY_5,
  input logic        WIRE_HEAT_ACCUMULATE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // six quiet cycles cover the sync flops and the output flop
  a_gate_off_idle: assert property (
    !SWITCH_ON_COMMAND [*6] |-> !GATE_ON) else $error("gate on while switch off");
  a_warn_clears: assert property (
    !OVERTEMP_RAW [*6] ##0 (REG_RD && REG_ADDR == 8'h15) |=> !REG_RDATA[0])
    else $error("warning bit stuck");
  a_open_load_gated: assert property (
    !OPEN_LOAD_DETECT_ENABLE [*6] ##0 (REG_RD && REG_ADDR == 8'h15) |=> !REG_RDATA[1])
    else $error("open load bit without enable");
  a_ctrl_top_zero: assert property (
    REG_RD && REG_ADDR == 8'h16 |=> REG_RDATA[15:12] == 4'h0) else $error("reserved bits set");
  a_divide_mode: assert property (
    CURRENT_DIVIDE_BY_5 |-> CHARGE_MODE == 2'h2) else $error("divide outside limit mode");
  a_no_heat_window: assert property (
    WIRE_HEAT_ACCUMULATE |-> !(INRUSH_ACTIVE && CHARGE_MODE != 2'h0))
    else $error("heating accumulates while charging");
  a_heat_waits_window: assert property (
    $rose(INRUSH_ACTIVE) && CHARGE_MODE != 2'h0 |-> !$past(WIRE_HEAT_ACCUMULATE))
    else $error("heating started before charge window");
  a_steady_code: assert property (
    (!INRUSH_ACTIVE && $stable(STEADY_OVERCURRENT_THRESHOLD)) ##1 !INRUSH_ACTIVE
    |-> OVERCURRENT_CODE == $past(STEADY_OVERCURRENT_THRESHOLD)) else $error("steady code lost");
  a_reset_code: assert property (
    $rose(RESETN) |-> OVERCURRENT_CODE == 4'h8) else $error("threshold reset value wrong");
endmodule // ch2_pwm_inrush_checker

bind ch2_pwm_inrush ch2_pwm_inrush_checker i_checker (.CLK(CLK), .RESETN(RESETN),
  .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .SWITCH_ON_COMMAND(SWITCH_ON_COMMAND), .OVERTEMP_RAW(OVERTEMP_RAW),
  .OPEN_LOAD_DETECT_ENABLE(OPEN_LOAD_DETECT_ENABLE),
  .STEADY_OVERCURRENT_THRESHOLD(STEADY_OVERCURRENT_THRESHOLD), .GATE_ON(GATE_ON),
  .INRUSH_ACTIVE(INRUSH_ACTIVE), .CHARGE_MODE(CHARGE_MODE),
  .OVERCURRENT_CODE(OVERCURRENT_CODE), .CURRENT_DIVIDE_BY_5(CURRENT_DIVIDE_BY_5),
  .WIRE_HEAT_ACCUMULATE(WIRE_HEAT_ACCUMULATE));

// ==== testbench/ch2_host_model.sv ====
module ch2_host_model (
  // clock
  input  logic        clk,
  // register port
  output logic [7:0]  reg_addr,
  output logic        reg_wr,
  output logic        reg_rd,
  output logic [15:0] reg_wdata,
  input  logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // one-cycle strobe; released lines show the inverse, not the last value
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(negedge clk);
    q = reg_rdata;
  endtask
endmodule // ch2_host_model

// ==== testbench/ch2_pwm_inrush_test.sv ====
module ch2_pwm_inrush_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, reg_wr, reg_rd, sw_on, hot, ol_raw, ol_en, gate, inrush, div5;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, q;
  logic        wheat;
  logic [3:0]  steady, oc_code, ramp, pparam;
  logic [1:0]  mode, peak;
  int          bad_count, check_count, cycles, n;
  typedef struct { logic [7:0] a; logic [15:0] d; logic [15:0] r; } row_t;
  row_t rows [5] = '{'{8'h17, 16'hFFFF, 16'hFFFF}, '{8'h17, 16'h5A3C, 16'h5A3C},
    '{8'h16, 16'hFFFE, 16'h0FFE}, '{8'h16, 16'h0E00, 16'h0E00}, '{8'h3C, 16'hFFFF, 16'h0000}};
  ch2_host_model i_ch2_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  ch2_pwm_inrush i_ch2_pwm_inrush (.CLK(clk), .RESETN(resetn), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .SWITCH_ON_COMMAND(sw_on), .OVERTEMP_RAW(hot), .OPEN_LOAD_RAW(ol_raw),
    .OPEN_LOAD_DETECT_ENABLE(ol_en), .STEADY_OVERCURRENT_THRESHOLD(steady),
    .GATE_ON(gate), .INRUSH_ACTIVE(inrush), .CHARGE_MODE(mode), .OVERCURRENT_CODE(oc_code),
    .CURRENT_DIVIDE_BY_5(div5), .RAMP_RATE_CODE(ramp), .PULSE_PARAM_CODE(pparam),
    .PULSE_PEAK_CURRENT_SELECT(peak), .WIRE_HEAT_ACCUMULATE(wheat));
  // ----
  // tasks
  // ----
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  // pulse lengths may drift by up to three cycles with the pipeline
  task automatic chk_len(input string w, input int e, input int g);
    check_count++;
    if (g < e - 3 || g > e + 3) begin
      bad_count++;
      $display("unexpected %s: expected %0d seen %0d", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_ch2_host_model.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    i_ch2_host_model.access(1'b0, a, 16'h0000, q);
  endtask
  task automatic span(input logic lvl);
    n = 0;
    while (gate === lvl && n < 30000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----
  // clock and hang guard
  // ----
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ceiling sits well above the three pulse phases measured
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    {resetn, sw_on, hot, ol_raw, ol_en} = 5'h00;
    steady = 4'h5;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    rd(8'h16);
    chk("pwm reset", 16'h0000, q);
    rd(8'h17);
    chk("limit reset", 16'h0088, q);
    chk("steady code", 16'(steady), 16'(oc_code));
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("readback", rows[i].r, q);
    end
    chk("mode out", 16'h0001, 16'(mode));
    chk("ramp code", 16'h0003, 16'(ramp));
    wr(8'h17, 16'h7AC0);
    chk("pulse param", 16'h000C, 16'(pparam));
    chk("peak select", 16'h0001, 16'(peak));
    chk("ramp idle", 16'h0000, 16'(ramp));
    $display("table test done");
    wr(8'h16, 16'h01FF);
    rd(8'h16);
    chk("enable refused", 16'h01FE, q);
    rd(8'h15);
    chk("error flag", 16'h1000, q & 16'h1000);
    rd(8'h15);
    chk("error cleared", 16'h0000, q & 16'h1000);
    wr(8'h17, 16'h0880);
    wr(8'h16, 16'h0EB5);
    rd(8'h16);
    chk("short on refused", 16'h0EB4, q);
    wr(8'h16, 16'h0EB7);
    rd(8'h16);
    chk("long on kept", 16'h0EB7, q);
    $display("enable test done");
    wr(8'h16, 16'h0000);
    sw_on = 1'b1;
    repeat (6) @(negedge clk);
    chk("gate follows", 16'h0001, 16'(gate));
    chk("heat on", 16'h0001, 16'(wheat));
    wr(8'h16, 16'h0F01);
    // the restart dips the gate for a cycle; let the first high phase settle
    repeat (4) @(negedge clk);
    span(1'b1);
    span(1'b0);
    chk_len("low phase", 14124, n);
    span(1'b1);
    chk_len("high phase", 14124, n);
    sw_on = 1'b0;
    repeat (6) @(negedge clk);
    chk("gate off", 16'h0000, 16'(gate));
    $display("pulse test done");
    ol_raw = 1'b1;
    for (int k = 3; k >= 0; k--) begin
      {hot, ol_en} = 2'(k);
      repeat (4) @(negedge clk);
      rd(8'h15);
      chk("status", 16'({k[0], k[1]}), q & 16'h0003);
    end
    $display("status test done");
    wr(8'h17, 16'h2988);
    sw_on = 1'b1;
    repeat (8) @(negedge clk);
    chk("window", 16'h0001, 16'(inrush));
    chk("limit mode", 16'h0003, 16'({mode == 2'h2, div5}));
    chk("heat held", 16'h0000, 16'(wheat));
    resetn = 1'b0;
    sw_on = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset code", 16'h0008, 16'(oc_code));
    resetn = 1'b1;
    rd(8'h17);
    chk("limit after reset", 16'h0088, q);
    $display("window test done");
    end_of_test();
  end
endmodule // ch2_pwm_inrush_test
